/* File: include/osmx_pkg.sv */
// shared constants and types of the optical sample multiplexer
`default_nettype none
package osmx_pkg;
  // clock of the jitter-cleaned recovered reference
  localparam int unsigned CLK_HZ = 50_000_000;
  // base frame rates of the optical ports
  localparam int unsigned BASE_44_HZ = 44_100;
  localparam int unsigned BASE_48_HZ = 48_000;
  // sample word and channel counts
  localparam int unsigned SMP_W = 24;
  localparam int unsigned IN_CH = 8;
  localparam int unsigned PORT_CH = 8;
  // quad-rate sample slots per base frame
  localparam int unsigned PHASES = 4;
  // clk cycles per quad-rate slot, rounded down
  localparam int unsigned QDIV_44 = CLK_HZ / (BASE_44_HZ * PHASES);
  localparam int unsigned QDIV_48 = CLK_HZ / (BASE_48_HZ * PHASES);
  localparam int unsigned DIV_W = 12;
  // codes on the rate_mode input
  localparam logic [1:0] MODE_CODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_CODE_DOUBLE = 2'h1;
  localparam logic [1:0] MODE_CODE_QUAD = 2'h2;
  // sample word placed in a slot that had no valid sample
  localparam logic [SMP_W-1:0] SMP_ZERO = 24'h00_0000;
  typedef enum logic [2:0]
  {
    OSMX_SINGLE = 3'h1,
    OSMX_DOUBLE = 3'h2,
    OSMX_QUAD = 3'h4
  } osmx_mode_t;
  typedef logic [SMP_W-1:0] osmx_smp_t;
endpackage : osmx_pkg
`default_nettype wire

/* File: hw/osmx_buf2.sv */
// two-entry buffer for assembled port frames
`default_nettype none
module osmx_buf2 #(
  parameter int unsigned W = 384
) (
  input wire logic clk, // recovered clock
  input wire logic reset, // sync, active high
  input wire logic [W-1:0] in_data, // frame to store
  input wire logic in_valid, // frame offered
  output logic in_ready, // room for a frame
  output logic [W-1:0] out_data, // head frame, registered
  output logic out_valid, // head frame present
  input wire logic out_ready // receiver takes head
);
  logic [W-1:0] head_ff, nxt_head, tail_ff, nxt_tail;
  logic head_v_ff, nxt_head_v, tail_v_ff, nxt_tail_v;
  logic pop, push;

  // spare entry lets the receiver stall one frame without loss
  always_comb
  begin
    nxt_head = head_ff;
    nxt_tail = tail_ff;
    nxt_head_v = head_v_ff;
    nxt_tail_v = tail_v_ff;
    pop = head_v_ff & out_ready;
    push = in_valid & ~tail_v_ff;
    if (pop)
    begin
      if (tail_v_ff)
      begin
        nxt_head = tail_ff;
        nxt_tail_v = 1'b0;
      end
      else
        nxt_head_v = 1'b0;
    end
    if (push)
    begin
      if (!head_v_ff || (pop && !tail_v_ff))
      begin
        nxt_head = in_data;
        nxt_head_v = 1'b1;
      end
      else
      begin
        nxt_tail = in_data;
        nxt_tail_v = 1'b1;
      end
    end
  end

  // entry registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      head_ff <= '0;
      tail_ff <= '0;
      head_v_ff <= 1'b0;
      tail_v_ff <= 1'b0;
    end
    else
    begin
      head_ff <= nxt_head;
      tail_ff <= nxt_tail;
      head_v_ff <= nxt_head_v;
      tail_v_ff <= nxt_tail_v;
    end
  end

  assign in_ready = ~tail_v_ff;
  assign out_valid = head_v_ff;
  assign out_data = head_ff;
endmodule : osmx_buf2
`default_nettype wire

/* File: hw/osmx_mux.sv */
// sample multiplexer onto two eight-channel optical ports
// Notes on behaviour
// RULE_01 - double rate takes samples twice per frame
// RULE_02 - samples stay full 24 bits wide
// RULE_03 - double rate splits channels automatically over pairs
// RULE_04 - channels 1-4 port one, 5-8 port two
// RULE_05 - alternate samples go to pair members
// RULE_06 - double rate frames still at base rate
// RULE_07 - quad rate uses four port channels each
// RULE_08 - quad rate: two channels per optical port
// RULE_09 - quad rate frames still at base rate
// RULE_10 - everything timed by recovered clean clock
// RULE_11 - earliest sample goes to lowest channel
`default_nettype none
module osmx_mux
  import osmx_pkg::*;
#(
  parameter int unsigned QDIV_A = osmx_pkg::QDIV_44,
  parameter int unsigned QDIV_B = osmx_pkg::QDIV_48
) (
  input wire logic clk, // jitter-cleaned recovered clock
  input wire logic reset, // sync, active high
  input wire logic [1:0] rate_mode, // single, double or quad code
  input wire logic family_48, // 1: 48 kHz family, 0: 44.1
  input wire osmx_pkg::osmx_smp_t [osmx_pkg::IN_CH-1:0] hs_data, // set
  input wire logic hs_valid, // high-rate sample set present
  output logic hs_ready, // sample set taken this cycle
  output logic frame_tick, // base frame boundary pulse
  output osmx_pkg::osmx_mode_t mode_active, // mode in force
  output osmx_pkg::osmx_smp_t [osmx_pkg::PORT_CH-1:0] port1_data, // one
  output osmx_pkg::osmx_smp_t [osmx_pkg::PORT_CH-1:0] port2_data, // two
  output logic out_valid, // port frame ready
  input wire logic out_ready, // link transmitter takes frame
  output logic sample_missing, // pulse: slot had no sample
  output logic frame_lost // pulse: frame overwritten
);
  import osmx_pkg::*;

  localparam int unsigned NP = 2 * PORT_CH;
  localparam int unsigned FW = NP * SMP_W;
  localparam logic [DIV_W-1:0] LIM_A = DIV_W'(QDIV_A - 1);
  localparam logic [DIV_W-1:0] LIM_B = DIV_W'(QDIV_B - 1);

  // where port channel p gets its sample: {hit, source, slot}
  function automatic logic [5:0] place(osmx_mode_t m, logic [3:0] p);
    logic [5:0] r;
    r = 6'h00;
    unique case (m)
      OSMX_SINGLE: r = {~p[3], p[2:0], 2'h0};
      OSMX_DOUBLE: r = {1'b1, p[3], p[2:1], 1'b0, p[0]};
      // RULE_08 two channels per port
      OSMX_QUAD: r = {1'b1, 1'b0, p[3], p[2], p[1:0]};
    endcase
    return r;
  endfunction : place

  // timebase and mode state
  logic [DIV_W-1:0] div_ff, nxt_div;
  logic [1:0] phase_ff, nxt_phase;
  osmx_mode_t mode_ff, nxt_mode;
  logic fam_ff, nxt_fam;
  logic qtick, take;
  logic [1:0] slot;
  logic [DIV_W-1:0] lim;

  // quad-rate slot divider; mode and family switch only at a boundary
  always_comb
  begin
    lim = fam_ff ? LIM_B : LIM_A;
    qtick = (div_ff == lim);
    nxt_div = qtick ? '0 : div_ff + DIV_W'(1);
    nxt_phase = qtick ? phase_ff + 2'h1 : phase_ff;
    frame_tick = qtick && (phase_ff == 2'h3);
    nxt_mode = mode_ff;
    nxt_fam = fam_ff;
    if (frame_tick)
    begin
      nxt_fam = family_48;
      unique case (rate_mode)
        MODE_CODE_DOUBLE: nxt_mode = OSMX_DOUBLE;
        MODE_CODE_QUAD: nxt_mode = OSMX_QUAD;
        default: nxt_mode = OSMX_SINGLE;
      endcase
    end
    // RULE_01 RULE_03 take slots
    take = 1'b0;
    slot = 2'h0;
    unique case (mode_ff)
      OSMX_SINGLE: take = qtick && (phase_ff == 2'h0);
      OSMX_DOUBLE:
      begin
        take = qtick && !phase_ff[0];
        slot = {1'b0, phase_ff[1]};
      end
      OSMX_QUAD:
      begin
        take = qtick;
        slot = phase_ff;
      end
    endcase
  end

  // RULE_10 single clock domain
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      div_ff <= '0;
      phase_ff <= 2'h0;
      mode_ff <= OSMX_SINGLE;
      fam_ff <= 1'b0;
    end
    else
    begin
      div_ff <= nxt_div;
      phase_ff <= nxt_phase;
      mode_ff <= nxt_mode;
      fam_ff <= nxt_fam;
    end
  end

  // RULE_02 full width assembly state
  osmx_smp_t [NP-1:0] asm_ff, nxt_asm, hold_ff, nxt_hold;
  logic pend_ff, nxt_pend, miss_ff, nxt_miss, lost_ff, nxt_lost;
  logic buf_in_ready;
  logic [5:0] pl;
  osmx_smp_t [NP-1:0] merged;

  // place the taken samples, then hand a full frame to the buffer;
  // the timebase cannot wait, so a stalled buffer costs a frame
  always_comb
  begin
    merged = asm_ff;
    pl = 6'h00;
    for (int p = 0; p < NP; p++)
    begin
      pl = place(mode_ff, 4'(p));
      // RULE_04 RULE_05 RULE_07 RULE_11 slot mapping
      if (take && pl[5] && (pl[1:0] == slot))
        merged[p] = hs_valid ? hs_data[pl[4:2]] : SMP_ZERO;
    end
    nxt_asm = merged;
    nxt_hold = hold_ff;
    nxt_pend = pend_ff && !buf_in_ready;
    nxt_lost = 1'b0;
    nxt_miss = take && !hs_valid;
    // RULE_06 RULE_09 base frame output
    if (frame_tick)
    begin
      nxt_hold = merged;
      nxt_asm = '0;
      nxt_pend = 1'b1;
      nxt_lost = pend_ff && !buf_in_ready;
    end
  end

  // assembly registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      asm_ff <= '0;
      hold_ff <= '0;
      pend_ff <= 1'b0;
      miss_ff <= 1'b0;
      lost_ff <= 1'b0;
    end
    else
    begin
      asm_ff <= nxt_asm;
      hold_ff <= nxt_hold;
      pend_ff <= nxt_pend;
      miss_ff <= nxt_miss;
      lost_ff <= nxt_lost;
    end
  end

  logic [FW-1:0] buf_out;

  // receiver stalls are absorbed here
  osmx_buf2 #(
    .W(FW)
  ) u_buf (
    .clk(clk),
    .reset(reset),
    .in_data(hold_ff),
    .in_valid(pend_ff),
    .in_ready(buf_in_ready),
    .out_data(buf_out),
    .out_valid(out_valid),
    .out_ready(out_ready)
  );

  // outputs
  assign port1_data = buf_out[FW/2-1:0];
  assign port2_data = buf_out[FW-1:FW/2];
  assign hs_ready = take;
  assign mode_active = mode_ff;
  assign sample_missing = miss_ff;
  assign frame_lost = lost_ff;

  // helper counters for the checks below
  logic [2:0] takes_ff;
  logic [DIV_W+1:0] gap_ff;
  logic seen_ff;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      takes_ff <= 3'h0;
      gap_ff <= '0;
      seen_ff <= 1'b0;
    end
    else
    begin
      takes_ff <= frame_tick ? 3'h0 : takes_ff + 3'(take);
      gap_ff <= frame_tick ? '0 : gap_ff + (DIV_W+2)'(1);
      seen_ff <= seen_ff | frame_tick;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_double_two_takes;
    frame_tick && mode_ff == OSMX_DOUBLE |-> takes_ff == 3'h2 && !take;
  endproperty
  a_double_two_takes: assert property (p_double_two_takes) // RULE_01
    else $error("double rate did not take two samples per frame");

  property p_double_even_slots;
    take && mode_ff == OSMX_DOUBLE |-> !phase_ff[0];
  endproperty
  a_double_even_slots: assert property (p_double_even_slots) // RULE_03
    else $error("double rate took a sample in an odd slot");

  property p_double_second;
    take && hs_valid && mode_ff == OSMX_DOUBLE && phase_ff == 2'h2
      |=> asm_ff[1] == $past(hs_data[0]) && asm_ff[15] == $past(hs_data[7]);
  endproperty
  a_double_second: assert property (p_double_second) // RULE_02
    else $error("second double rate sample misplaced");

  property p_double_first;
    take && hs_valid && mode_ff == OSMX_DOUBLE && phase_ff == 2'h0
      |=> asm_ff[0] == $past(hs_data[0]) && asm_ff[10] == $past(hs_data[5]);
  endproperty
  a_double_first: assert property (p_double_first) // RULE_05
    else $error("first double rate sample misplaced");

  property p_double_ports;
    take && hs_valid && mode_ff == OSMX_DOUBLE && phase_ff == 2'h0
      |=> asm_ff[6] == $past(hs_data[3]) && asm_ff[8] == $past(hs_data[4]);
  endproperty
  a_double_ports: assert property (p_double_ports) // RULE_04
    else $error("double rate channel on wrong port");

  property p_quad_last;
    take && hs_valid && mode_ff == OSMX_QUAD && phase_ff == 2'h3
      |=> hold_ff[7] == $past(hs_data[1]) && hold_ff[11] == $past(hs_data[2]);
  endproperty
  a_quad_last: assert property (p_quad_last) // RULE_07
    else $error("last quad rate sample misplaced");

  property p_quad_order;
    take && hs_valid && mode_ff == OSMX_QUAD && phase_ff == 2'h0
      |=> asm_ff[8] == $past(hs_data[2]) && asm_ff[12] == $past(hs_data[3]);
  endproperty
  a_quad_order: assert property (p_quad_order) // RULE_08
    else $error("quad rate port two content wrong");

  property p_frame_rate;
    frame_tick && seen_ff |-> gap_ff == (DIV_W+2)'(PHASES) * (lim + 1) - 1;
  endproperty
  a_frame_rate: assert property (p_frame_rate) // RULE_06
    else $error("base frame spacing wrong");

  property p_quad_takes;
    frame_tick && mode_ff == OSMX_QUAD |-> takes_ff == 3'h3 ##1 !frame_tick;
  endproperty
  a_quad_takes: assert property (p_quad_takes) // RULE_09
    else $error("quad rate frame did not take four samples");

  property p_earliest_low;
    take && hs_valid && mode_ff == OSMX_QUAD && phase_ff == 2'h1
      |=> asm_ff[1] == $past(hs_data[0]);
  endproperty
  a_earliest_low: assert property (p_earliest_low) // RULE_11
    else $error("quad rate slot order wrong");

  property p_out_hold;
    out_valid && !out_ready |=> out_valid && $stable(port1_data);
  endproperty
  a_out_hold: assert property (p_out_hold) // RULE_10
    else $error("output frame changed while stalled");

  c_double: cover property (frame_tick && mode_ff == OSMX_DOUBLE);
  c_quad: cover property (frame_tick && mode_ff == OSMX_QUAD);
  c_lost: cover property (frame_lost);
  c_stall: cover property (out_valid && !out_ready ##1 out_ready);
endmodule : osmx_mux
`default_nettype wire

/* File: verification/osmx_link_sink.sv */
// link transmitter model that takes port frames with stalls
`default_nettype none
module osmx_link_sink (
  input wire logic clk, // recovered clock
  input wire logic reset, // sync, active high
  input wire logic hold_off, // 1: refuse every frame
  output logic out_ready // frame taken when valid too
);
  timeunit 1ns;
  timeprecision 1ps;
  // short random stalls; a real transmitter is not always free
  always @(posedge clk)
  begin
    out_ready <= !reset && !hold_off && (($urandom % 4) != 0);
  end
endmodule : osmx_link_sink
`default_nettype wire

/* File: verification/osmx_mux_bench.sv */
// self-checking bench of the optical sample multiplexer
`default_nettype none
module osmx_mux_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import osmx_pkg::*;
  // short slots keep the run brief
  localparam int QA = 4;
  localparam int QB = 5;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] rate_mode = 2'h0;
  logic family_48 = 1'b0;
  osmx_smp_t [IN_CH-1:0] hs_data = '0;
  logic hs_valid = 1'b0;
  logic hold_off = 1'b0;
  logic hs_ready, frame_tick, out_valid, out_ready;
  logic sample_missing, frame_lost;
  osmx_mode_t mode_active;
  osmx_smp_t [PORT_CH-1:0] port1_data, port2_data;
  osmx_smp_t [IN_CH-1:0] sl [4];
  logic [383:0] exp_q [$];
  int num_errors = 0, check_count = 0, cyc = 0, last = 0, k = 0;
  int lost_exp = 0, lost_seen = 0;
  logic [1:0] cur_mode = 2'h0;
  logic cur_fam = 1'b0, miss_q = 1'b0;

  osmx_mux #(.QDIV_A(QA), .QDIV_B(QB)) osmx_mux_i (.clk(clk),
    .reset(reset), .rate_mode(rate_mode), .family_48(family_48),
    .hs_data(hs_data), .hs_valid(hs_valid), .hs_ready(hs_ready),
    .frame_tick(frame_tick), .mode_active(mode_active),
    .port1_data(port1_data), .port2_data(port2_data),
    .out_valid(out_valid), .out_ready(out_ready),
    .sample_missing(sample_missing), .frame_lost(frame_lost));
  osmx_link_sink osmx_link_sink_i (.clk(clk), .reset(reset),
    .hold_off(hold_off), .out_ready(out_ready));

  // 50 MHz clock
  always #10 clk = ~clk;

  task automatic chk_frame(input string what, input logic [383:0] e,
    input logic [383:0] g);
    check_count++;
    if (e !== g)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk_frame

  task automatic chk_num(input string what, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (e !== g)
    begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk_num

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  function automatic osmx_mode_t mode_of(input logic [1:0] m);
    if (m == MODE_CODE_DOUBLE)
      return OSMX_DOUBLE;
    if (m == MODE_CODE_QUAD)
      return OSMX_QUAD;
    return OSMX_SINGLE;
  endfunction : mode_of

  // expected port frame from the slots of one base frame
  function automatic logic [383:0] frame_of(input logic [1:0] m);
    osmx_smp_t [PORT_CH-1:0] p1, p2;
    p1 = '0;
    p2 = '0;
    for (int c = 0; c < 4; c++)
    begin
      if (m == MODE_CODE_DOUBLE)
      begin
        p1[2*c] = sl[0][c];
        p1[2*c+1] = sl[1][c];
        p2[2*c] = sl[0][c+4];
        p2[2*c+1] = sl[1][c+4];
      end
      else if (m == MODE_CODE_QUAD)
      begin
        p1[c] = sl[c][0];
        p1[c+4] = sl[c][1];
        p2[c] = sl[c][2];
        p2[c+4] = sl[c][3];
      end
      else
      begin
        p1[c] = sl[0][c];
        p1[c+4] = sl[0][c+4];
      end
    end
    return {p2, p1};
  endfunction : frame_of

  // cycle count and hang limit
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      num_errors++;
      complete_run();
    end
  end

  // random samples; some slots left empty on purpose
  always @(posedge clk)
  begin
    for (int c = 0; c < IN_CH; c++)
      hs_data[c] <= osmx_smp_t'($urandom);
    hs_valid <= ($urandom % 8) != 0;
  end

  // reference model, sampled mid-cycle so every edge has settled
  always @(negedge clk)
  begin
    if (reset)
    begin
      k = 0;
      last = 0;
      cur_mode = 2'h0;
      cur_fam = 1'b0;
      miss_q = 1'b0;
      exp_q.delete();
    end
    else
    begin
      chk_num("sample_missing", miss_q, sample_missing);
      miss_q = hs_ready && !hs_valid;
      if (hs_ready)
      begin
        chk_num("mode_active", mode_of(cur_mode), mode_active);
        if (k < 4)
          sl[k] = hs_valid ? hs_data : '0;
        k++;
      end
      if (frame_tick)
      begin
        chk_num("slots", cur_mode == MODE_CODE_QUAD ? 4 :
          cur_mode == MODE_CODE_DOUBLE ? 2 : 1, k);
        if (last != 0)
          chk_num("period", 4 * (cur_fam ? QB : QA), cyc - last);
        last = cyc;
        // a full store loses its newest waiting frame
        if (exp_q.size() == 3)
        begin
          exp_q.delete(2);
          lost_exp++;
        end
        exp_q.push_back(frame_of(cur_mode));
        k = 0;
        cur_mode = rate_mode;
        cur_fam = family_48;
      end
      // pop after the boundary: a full store refuses even while it pops
      if (out_valid && out_ready)
        chk_frame("port frame", exp_q.size() > 0 ? exp_q.pop_front() : 'x,
          {port2_data, port1_data});
      if (frame_lost)
        lost_seen++;
    end
  end

  task automatic wait_ticks(input int n);
    repeat (n)
    begin
      @(negedge clk);
      while (!frame_tick)
        @(negedge clk);
    end
  endtask : wait_ticks

  // every mode code and both families, one long receiver stall
  initial
  begin
    void'($urandom(32'hf9735234));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (int t = 0; t < 7; t++)
    begin
      @(posedge clk);
      rate_mode <= t[1:0];
      family_48 <= t[0];
      hold_off <= (t == 4);
      wait_ticks(6);
      $display("test %0d done errors %0d", t, num_errors);
    end
    @(posedge clk);
    hold_off <= 1'b0;
    wait_ticks(3);
    chk_num("frames lost", lost_exp, lost_seen);
    chk_num("stall lost a frame", 1, lost_exp > 0);
    complete_run();
  end
endmodule : osmx_mux_bench
`default_nettype wire
